/* iet_pkg.sv */
// package: constants and types for the instruction execution core
package iet_pkg;
	localparam int PC_W           = 11;
	localparam int DA_W           = 7;
	localparam int IW             = 14;
	localparam int DW             = 8;
	localparam int STACK_DEPTH    = 4;
	localparam int CLK_HZ         = 10_000_000;
	localparam int CLKS_PER_CYCLE = 4;
	localparam int PH_W           = $clog2(CLKS_PER_CYCLE);

	// phases of one instruction cycle
	localparam logic [1:0] PH_FETCH  = 2'h0;
	localparam logic [1:0] PH_DECODE = 2'h1;
	localparam logic [1:0] PH_READ   = 2'h2;
	localparam logic [1:0] PH_EXEC   = 2'h3;

	localparam logic [PC_W-1:0] PC_RESET  = 11'h000;
	localparam logic [DA_W-1:0] PCL_ADDR  = 7'h02;
	localparam logic [2:0]      TBL_PAGE  = 3'h7;
	localparam logic [IW-1:0]   IR_RESET  = 14'h0000;
	localparam logic [DW-1:0]   ZERO_BYTE = 8'h00;

	// instruction word field positions
	localparam int F_GRP  = 12;
	localparam int F_DEST = 11;
	localparam int F_ALU  = 7;
	localparam int F_IOP  = 8;
	localparam int F_BFN  = 10;
	localparam int F_BIDX = 7;
	localparam int F_CALL = 11;

	// instruction groups
	localparam logic [1:0] GRP_MEM = 2'h0;
	localparam logic [1:0] GRP_IMM = 2'h1;
	localparam logic [1:0] GRP_BIT = 2'h2;
	localparam logic [1:0] GRP_BR  = 2'h3;

	// bit group functions
	localparam logic [1:0] BIT_SET      = 2'h0;
	localparam logic [1:0] BIT_CLEAR    = 2'h1;
	localparam logic [1:0] BIT_SKIP_SET = 2'h2;
	localparam logic [1:0] BIT_SKIP_CLR = 2'h3;

	// immediate group: skip if memory zero
	localparam logic [3:0] IMM_SKIP_ZERO = 4'h8;

	// system codes in the address field of the special op
	localparam logic [DA_W-1:0] SYS_NOP      = 7'h00;
	localparam logic [DA_W-1:0] SYS_HALT     = 7'h01;
	localparam logic [DA_W-1:0] SYS_SUB_EXIT = 7'h02;
	localparam logic [DA_W-1:0] SYS_INT_EXIT = 7'h03;

	typedef enum logic [3:0] {
		ALU_MOVE            = 4'h0,
		ALU_ADD             = 4'h1,
		ALU_ADD_CARRY       = 4'h2,
		ALU_SUB             = 4'h3,
		ALU_SUB_CARRY       = 4'h4,
		ALU_AND             = 4'h5,
		ALU_OR              = 4'h6,
		ALU_XOR             = 4'h7,
		ALU_COMPLEMENT      = 4'h8,
		ALU_ADD_ONE         = 4'h9,
		ALU_SUB_ONE         = 4'ha,
		ALU_ROT_RIGHT       = 4'hb,
		ALU_ROT_LEFT        = 4'hc,
		ALU_ROT_RIGHT_CARRY = 4'hd,
		ALU_ROT_LEFT_CARRY  = 4'he,
		ALU_SPECIAL         = 4'hf
	} iet_alu_op_type;

	typedef enum logic [2:0] {
		ST_RUN   = 3'h1,
		ST_EXTRA = 3'h2,
		ST_HALT  = 3'h4
	} iet_state_type;
endpackage

/* iet_alu.sv */
// arithmetic, logic and rotate unit of the core
`timescale 1ns/10ps
module iet_alu
	import iet_pkg::*;
(
	// operation
	input  wire iet_alu_op_type op,
	input  wire logic           dest_mem,
	// operands
	input  wire logic [DW-1:0]  acc,
	input  wire logic [DW-1:0]  opnd,
	input  wire logic           carry_in,
	// result and flags
	output logic      [DW-1:0]  result,
	output logic                c_out,
	output logic                ac_out,
	output logic                ov_out,
	output logic                z_out,
	output logic                upd_z,
	output logic                upd_c,
	output logic                upd_acov
);
	wire logic          is_sub   = (op == ALU_SUB) || (op == ALU_SUB_CARRY);
	wire logic          is_arith = (op == ALU_ADD) || (op == ALU_ADD_CARRY) || is_sub;
	wire logic [DW-1:0] opnd_x   = is_sub ? ~opnd : opnd;
	wire logic          cin      = (op == ALU_ADD) ? 1'b0 : (op == ALU_SUB) ? 1'b1 : carry_in;
	wire logic [DW:0]   sum      = {1'b0, acc} + {1'b0, opnd_x} + {8'h00, cin};
	wire logic [4:0]    half     = {1'b0, acc[3:0]} + {1'b0, opnd_x[3:0]} + {4'h0, cin};
	wire logic          rot_c    = (op == ALU_ROT_RIGHT_CARRY) || (op == ALU_ROT_LEFT_CARRY);

	always_comb begin
		case (op)
			ALU_MOVE:            result = dest_mem ? acc : opnd;
			ALU_ADD,
			ALU_ADD_CARRY,
			ALU_SUB,
			ALU_SUB_CARRY:       result = sum[DW-1:0];
			ALU_AND:             result = acc & opnd;
			ALU_OR:              result = acc | opnd;
			ALU_XOR:             result = acc ^ opnd;
			ALU_COMPLEMENT:      result = ~opnd;
			ALU_ADD_ONE:         result = opnd + 8'h01;
			ALU_SUB_ONE:         result = opnd - 8'h01;
			ALU_ROT_RIGHT:       result = {opnd[0], opnd[DW-1:1]};
			ALU_ROT_LEFT:        result = {opnd[DW-2:0], opnd[DW-1]};
			ALU_ROT_RIGHT_CARRY: result = {carry_in, opnd[DW-1:1]};
			ALU_ROT_LEFT_CARRY:  result = {opnd[DW-2:0], carry_in};
			default:             result = opnd;
		endcase
	end

	// carry set means no borrow on subtraction
	assign c_out    = is_arith ? sum[DW] : (op == ALU_ROT_RIGHT_CARRY) ? opnd[0] : opnd[DW-1];
	assign ac_out   = half[4];
	assign ov_out   = (acc[DW-1] == opnd_x[DW-1]) && (sum[DW-1] != acc[DW-1]);
	assign z_out    = (result == ZERO_BYTE);
	assign upd_c    = is_arith || rot_c;
	assign upd_acov = is_arith;
	assign upd_z    = is_arith || ((op >= ALU_AND) && (op <= ALU_SUB_ONE));
endmodule

/* iet_core.sv */
// instruction sequencing and execution core
`timescale 1ns/10ps
module iet_core
	import iet_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// program memory, one clock read latency
	output logic      [PC_W-1:0] prog_addr,
	input  wire logic [IW-1:0]   prog_rdata,
	// data memory, one clock read latency
	output logic      [DA_W-1:0] dmem_addr,
	input  wire logic [DW-1:0]   dmem_rdata,
	output logic                 dmem_wr_en,
	output logic      [DW-1:0]   dmem_wr_data,
	// wake and interrupt control
	input  wire logic            wake_pin,
	input  wire logic            int_taken,
	output logic                 int_enable,
	output logic                 power_down,
	// status
	output logic      [DW-1:0]   acc,
	output logic                 flag_c,
	output logic                 flag_z,
	output logic                 flag_ac,
	output logic                 flag_ov,
	output logic      [5:0]      tbl_high
);
	localparam int SP_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	iet_state_type          state;
	iet_state_type          next_state;
	logic [PH_W-1:0]        phase;
	logic [PC_W-1:0]        pc;
	logic [IW-1:0]          ir;
	logic [SP_W-1:0]        sp;
	logic [PC_W-1:0]        stack_mem [DEPTH];
	logic                   tab_pending;
	logic [1:0]             wake_sync;

	// phase divider gives the execute enable
	wire logic cyc_end = (phase == PH_EXEC);
	wire logic fetch_latch = (phase == PH_DECODE);

	// decode
	wire logic [1:0]        grp     = ir[F_GRP +: 2];
	wire logic              m_dest  = ir[F_DEST];
	wire iet_alu_op_type    m_alu   = iet_alu_op_type'(ir[F_ALU +: 4]);
	wire logic [3:0]        i_op    = ir[F_IOP +: 4];
	wire logic [1:0]        b_fn    = ir[F_BFN +: 2];
	wire logic [2:0]        b_idx   = ir[F_BIDX +: 3];
	wire logic [DA_W-1:0]   sys_cd  = ir[DA_W-1:0];
	wire logic [PC_W-1:0]   target  = ir[PC_W-1:0];
	wire logic              is_mem  = (grp == GRP_MEM);
	wire logic              is_spec = is_mem && (m_alu == ALU_SPECIAL);
	wire logic              is_sys  = is_spec && !m_dest;
	wire logic              is_tab  = is_spec && m_dest;
	wire logic              is_halt = is_sys && (sys_cd == SYS_HALT);
	wire logic              is_sret = is_sys && (sys_cd == SYS_SUB_EXIT);
	wire logic              is_iret = is_sys && (sys_cd == SYS_INT_EXIT);
	wire logic              is_imm  = (grp == GRP_IMM) && !i_op[3];
	wire logic              is_sz   = (grp == GRP_IMM) && (i_op == IMM_SKIP_ZERO);
	wire logic              is_bit  = (grp == GRP_BIT);
	wire logic              is_br   = (grp == GRP_BR);
	wire logic              is_jmp  = is_br && !ir[F_CALL];
	wire logic              is_call = is_br && ir[F_CALL];

	// operand selection; the pc low byte is read from the core itself
	wire logic [DW-1:0]     mem_val = (dmem_addr == PCL_ADDR) ? pc[DW-1:0] : dmem_rdata;
	wire logic [DW-1:0]     imm_val = ir[DW-1:0];
	wire iet_alu_op_type    alu_op  = is_imm ? iet_alu_op_type'(i_op) : m_alu;
	wire logic [DW-1:0]     alu_b   = is_imm ? imm_val : mem_val;
	logic [DW-1:0]          alu_res;
	logic                   alu_c;
	logic                   alu_ac;
	logic                   alu_ov;
	logic                   alu_z;
	logic                   upd_z;
	logic                   upd_c;
	logic                   upd_acov;

	iet_alu u_alu (
		.op       (alu_op),
		.dest_mem (m_dest && !is_imm),
		.acc      (acc),
		.opnd     (alu_b),
		.carry_in (flag_c),
		.result   (alu_res),
		.c_out    (alu_c),
		.ac_out   (alu_ac),
		.ov_out   (alu_ov),
		.z_out    (alu_z),
		.upd_z    (upd_z),
		.upd_c    (upd_c),
		.upd_acov (upd_acov)
	);

	// bit manipulation and tests
	wire logic [DW-1:0] bit_mask = 8'h01 << b_idx;
	wire logic [DW-1:0] bit_val  = (b_fn == BIT_SET) ? (mem_val | bit_mask)
		: (mem_val & ~bit_mask);
	wire logic bit_test = mem_val[b_idx];
	wire logic skip_taken = (is_bit && (b_fn == BIT_SKIP_SET) && bit_test)
		|| (is_bit && (b_fn == BIT_SKIP_CLR) && !bit_test)
		|| (is_sz && (mem_val == ZERO_BYTE));

	// write-back selection
	wire logic wr_mem  = (is_mem && m_dest && !is_spec) || (is_bit && !b_fn[1]);
	wire logic wr_acc  = (is_mem && !m_dest && !is_spec) || is_imm;
	wire logic [DW-1:0] wr_val = is_bit ? bit_val : alu_res;
	wire logic pcl_wr  = wr_mem && (dmem_addr == PCL_ADDR);
	wire logic two_cyc = is_jmp || is_call || is_sret || is_iret || is_tab
		|| pcl_wr || skip_taken;

	// next program counter
	wire logic [SP_W-1:0] sp_dec  = sp - 1'b1;
	wire logic [PC_W-1:0] pc_inc  = pc + 11'h001;
	wire logic [PC_W-1:0] pc_skip = pc + 11'h002;
	wire logic [PC_W-1:0] ret_pc  = stack_mem[sp_dec];
	wire logic [PC_W-1:0] next_pc = (is_jmp || is_call) ? target
		: (is_sret || is_iret) ? ret_pc
		: pcl_wr ? {pc[PC_W-1:DW], wr_val}
		: skip_taken ? pc_skip
		: pc_inc;
	wire logic [PC_W-1:0] tbl_addr = {TBL_PAGE, acc};
	wire logic exec_run = cyc_end && (state == ST_RUN);

	always_comb begin
		case (state)
			ST_RUN: begin
				if (is_halt)
					next_state = ST_HALT;
				else if (two_cyc)
					next_state = ST_EXTRA;
				else
					next_state = ST_RUN;
			end
			ST_EXTRA: next_state = ST_RUN;
			ST_HALT:  next_state = wake_sync[1] ? ST_RUN : ST_HALT;
			default:  next_state = ST_RUN;
		endcase
	end

	assign power_down = (state == ST_HALT);

	// phase counter and sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase     <= '0;
			state     <= ST_RUN;
			wake_sync <= 2'h0;
		end else begin
			phase     <= phase + 1'b1;
			wake_sync <= {wake_sync[0], wake_pin};
			if (cyc_end)
				state <= next_state;
		end
	end

	// fetch path
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ir        <= IR_RESET;
			dmem_addr <= '0;
		end else if (fetch_latch && (state == ST_RUN)) begin
			ir        <= prog_rdata;
			dmem_addr <= prog_rdata[DA_W-1:0];
		end
	end

	// program counter and program memory address
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc          <= PC_RESET;
			prog_addr   <= PC_RESET;
			tab_pending <= 1'b0;
		end else if (exec_run && !is_halt) begin
			pc          <= next_pc;
			prog_addr   <= is_tab ? tbl_addr : next_pc;
			tab_pending <= is_tab;
		end else if (exec_run) begin
			pc          <= pc_inc;
			prog_addr   <= pc_inc;
		end else if (cyc_end && (state == ST_EXTRA)) begin
			prog_addr   <= pc;
			tab_pending <= 1'b0;
		end
	end

	// return address stack
	always_ff @(posedge clk) begin
		if (sys_rst)
			sp <= '0;
		else if (exec_run && is_call) begin
			stack_mem[sp] <= pc_inc;
			sp            <= sp + 1'b1;
		end else if (exec_run && (is_sret || is_iret))
			sp <= sp_dec;
	end

	// accumulator and flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc     <= ZERO_BYTE;
			flag_c  <= 1'b0;
			flag_z  <= 1'b0;
			flag_ac <= 1'b0;
			flag_ov <= 1'b0;
		end else if (exec_run && (wr_acc || wr_mem) && !is_bit) begin
			if (wr_acc)
				acc <= alu_res;
			if (upd_c)
				flag_c <= alu_c;
			if (upd_z)
				flag_z <= alu_z;
			if (upd_acov) begin
				flag_ac <= alu_ac;
				flag_ov <= alu_ov;
			end
		end
	end

	// data memory write and table capture
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dmem_wr_en   <= 1'b0;
			dmem_wr_data <= ZERO_BYTE;
			tbl_high     <= 6'h00;
		end else if (exec_run && wr_mem && !pcl_wr) begin
			dmem_wr_en   <= 1'b1;
			dmem_wr_data <= wr_val;
		end else if (fetch_latch && (state == ST_EXTRA) && tab_pending) begin
			dmem_wr_data <= prog_rdata[DW-1:0];
			tbl_high     <= prog_rdata[IW-1:DW];
		end else if (cyc_end && (state == ST_EXTRA) && tab_pending)
			dmem_wr_en <= 1'b1;
		else
			dmem_wr_en <= 1'b0;
	end

	// interrupt enable; re-enable wins over a same-cycle take
	always_ff @(posedge clk) begin
		if (sys_rst)
			int_enable <= 1'b0;
		else if (exec_run && is_iret)
			int_enable <= 1'b1;
		else if (int_taken)
			int_enable <= 1'b0;
	end
endmodule

/* iet_core_sva.sv */
// assertion checker for the execution core ports
`timescale 1ns/10ps
module iet_core_sva
	import iet_pkg::*;
(
	// clock and reset
	input wire logic            clk,
	input wire logic            sys_rst,
	// memory side
	input wire logic [PC_W-1:0] prog_addr,
	input wire logic [DA_W-1:0] dmem_addr,
	input wire logic            dmem_wr_en,
	// control and status
	input wire logic            int_taken,
	input wire logic            int_enable,
	input wire logic            power_down,
	input wire logic [DW-1:0]   acc,
	input wire logic [5:0]      tbl_high
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_addr_hold;
		$changed(prog_addr) |=> $stable(prog_addr)[*3];
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved mid cycle");

	property p_wr_gap;
		dmem_wr_en |=> !dmem_wr_en[*3];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("two writes in one cycle");

	property p_no_pcl;
		dmem_wr_en |-> dmem_addr != PCL_ADDR;
	endproperty
	a_no_pcl: assert property (p_no_pcl) else $error("pc low byte write reached memory");

	property p_halt_quiet;
		power_down |-> !dmem_wr_en;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("write while halted");

	property p_acc_hold;
		$changed(acc) |=> $stable(acc)[*3];
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("acc moved mid cycle");

	property p_ie_clear;
		$fell(int_enable) |-> $past(int_taken);
	endproperty
	a_ie_clear: assert property (p_ie_clear) else $error("int enable fell by itself");

	property p_tbl_write;
		$changed(tbl_high) |-> ##[1:4] dmem_wr_en;
	endproperty
	a_tbl_write: assert property (p_tbl_write) else $error("table word not written");

	property p_wr_align;
		$rose(dmem_wr_en) |-> $changed(prog_addr);
	endproperty
	a_wr_align: assert property (p_wr_align) else $error("write off cycle boundary");

	c_halt: cover property ($rose(power_down));
	c_int_exit: cover property ($rose(int_enable));
	c_tbl: cover property ($changed(tbl_high));
endmodule

bind iet_core iet_core_sva u_sva (
	.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .dmem_addr(dmem_addr),
	.dmem_wr_en(dmem_wr_en), .int_taken(int_taken), .int_enable(int_enable),
	.power_down(power_down), .acc(acc), .tbl_high(tbl_high)
);

/* iet_mem_model.sv */
// program and data memory model facing the core
`timescale 1ns/10ps
module iet_mem_model
	import iet_pkg::*;
(
	// clock
	input  wire logic            clk,
	// program side
	input  wire logic [PC_W-1:0] prog_addr,
	output logic      [IW-1:0]   prog_rdata,
	// data side
	input  wire logic [DA_W-1:0] dmem_addr,
	output logic      [DW-1:0]   dmem_rdata,
	input  wire logic            dmem_wr_en,
	input  wire logic [DW-1:0]   dmem_wr_data
);
	logic [IW-1:0] pm [2**PC_W];
	logic [DW-1:0] dm [2**DA_W];
	initial begin
		prog_rdata = '0;
		dmem_rdata = '0;
	end
	// sync reads, one clock latency
	always @(posedge clk) begin
		prog_rdata <= pm[prog_addr];
		dmem_rdata <= dm[dmem_addr];
		if (dmem_wr_en) begin
			dm[dmem_addr] <= dmem_wr_data;
		end
	end
endmodule

/* tb_top.sv */
// self-checking bench for the execution core
`timescale 1ns/10ps
module tb_top;
	import iet_pkg::*;
	logic            clk, sys_rst, wake_pin, int_taken;
	logic [PC_W-1:0] prog_addr, prev_addr;
	logic [IW-1:0]   prog_rdata, w;
	logic [DA_W-1:0] dmem_addr;
	logic [DW-1:0]   dmem_rdata, dmem_wr_data, acc, r0, t, d6;
	logic            dmem_wr_en, int_enable, power_down, flag_c, flag_z, flag_ac, flag_ov;
	logic [5:0]      tbl_high;
	logic [2:0]      b, b2;
	logic [8:0]      a1;
	logic [DW-1:0]   pre [2**DA_W];
	int              err_count, total_checks, cyc, seed, i;
	int              lv [2**PC_W];

	iet_core DUT (
		.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
		.dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_wr_en(dmem_wr_en),
		.dmem_wr_data(dmem_wr_data), .wake_pin(wake_pin), .int_taken(int_taken),
		.int_enable(int_enable), .power_down(power_down), .acc(acc), .flag_c(flag_c),
		.flag_z(flag_z), .flag_ac(flag_ac), .flag_ov(flag_ov), .tbl_high(tbl_high)
	);
	iet_mem_model mem (
		.clk(clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .dmem_addr(dmem_addr),
		.dmem_rdata(dmem_rdata), .dmem_wr_en(dmem_wr_en), .dmem_wr_data(dmem_wr_data)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// clock count at which each address was last left
	always @(posedge clk) begin
		cyc++;
		if (!sys_rst && prog_addr !== prev_addr) begin
			lv[prev_addr] = cyc;
		end
		prev_addr = prog_addr;
	end

	function automatic logic [DW-1:0] put_bit(input logic [DW-1:0] v, input logic [2:0] k,
			input logic s);
		put_bit = v;
		put_bit[k] = s;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wait_pd(input logic lvl);
		int n;
		n = 0;
		while (power_down !== lvl && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 1000) begin
			chk(16'h0000, 16'h0001);
			summarize();
		end
	endtask

	initial begin
		seed = 14;
		sys_rst = 1'b1;
		wake_pin = 1'b0;
		int_taken = 1'b0;
		for (i = 0; i < 2**PC_W; i++) mem.pm[i] = {3'h0, ALU_SPECIAL, SYS_NOP};
		for (i = 0; i < 2**DA_W; i++) mem.dm[i] = 8'($random(seed));
		mem.dm[7'h10] = 8'hff;
		mem.dm[7'h17] = 8'h00;
		pre = mem.dm;
		r0 = 8'($random(seed));
		t = 8'($random(seed));
		w = 14'($random(seed));
		b = 3'($random(seed));
		b2 = 3'($random(seed));
		a1 = {1'b0, r0} + {1'b0, pre[7'h10]};
		d6 = pre[7'h13] - 8'h01;
		mem.pm[0] = {2'h1, ALU_MOVE, r0};
		mem.pm[1] = {3'h0, ALU_ADD, 7'h10};
		mem.pm[2] = {3'h1, ALU_MOVE, 7'h20};
		mem.pm[3] = {3'h0, ALU_XOR, 7'h11};
		mem.pm[4] = {3'h1, ALU_MOVE, 7'h21};
		mem.pm[5] = {3'h1, ALU_ADD_ONE, 7'h12};
		mem.pm[6] = {3'h0, ALU_SUB_ONE, 7'h13};
		mem.pm[7] = {3'h1, ALU_MOVE, 7'h22};
		mem.pm[8] = {3'h1, ALU_ROT_LEFT_CARRY, 7'h14};
		mem.pm[9] = {2'h2, BIT_SET, b, 7'h15};
		mem.pm[10] = {2'h2, BIT_CLEAR, b2, 7'h16};
		mem.pm[11] = {2'h1, IMM_SKIP_ZERO, 8'h17};
		mem.pm[12] = {2'h1, ALU_MOVE, 8'h55};
		mem.pm[13] = {3'h1, ALU_MOVE, 7'h23};
		mem.pm[14] = {2'h2, BIT_SKIP_SET, b2, 7'h16};
		mem.pm[15] = {3'h7, 11'h014};
		mem.pm[16] = {3'h6, 11'h018};
		mem.pm[20] = {2'h1, ALU_XOR, d6};
		mem.pm[21] = {3'h0, ALU_SPECIAL, SYS_SUB_EXIT};
		mem.pm[24] = {2'h1, ALU_MOVE, t};
		mem.pm[25] = {3'h1, ALU_SPECIAL, 7'h24};
		mem.pm[26] = {2'h1, ALU_MOVE, 8'h1e};
		mem.pm[27] = {3'h1, ALU_MOVE, PCL_ADDR};
		mem.pm[28] = {3'h1, ALU_MOVE, 7'h25};
		mem.pm[30] = {3'h7, 11'h028};
		mem.pm[31] = {3'h0, ALU_SPECIAL, SYS_HALT};
		mem.pm[32] = {3'h1, ALU_MOVE, 7'h26};
		mem.pm[33] = {3'h0, ALU_SPECIAL, SYS_HALT};
		mem.pm[40] = {3'h0, ALU_SPECIAL, SYS_INT_EXIT};
		mem.pm[{TBL_PAGE, t}] = w;
		repeat (12) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		wait_pd(1'b1);
		chk(16'(lv[2] - lv[1]), 16'h0004);
		chk(16'(lv[13] - lv[11]), 16'h0008);
		chk(16'(lv[15] - lv[14]), 16'h0004);
		chk(16'(lv[20] - lv[15]), 16'h0008);
		chk(16'(lv[16] - lv[21]), 16'h0008);
		chk(16'(lv[24] - lv[16]), 16'h0008);
		chk(16'(lv[26] - lv[25]), 16'h0008);
		chk(16'(lv[30] - lv[27]), 16'h0008);
		chk(mem.dm[7'h20], a1[7:0]);
		chk(mem.dm[7'h21], a1[7:0] ^ pre[7'h11]);
		chk(mem.dm[7'h12], pre[7'h12] + 8'h01);
		chk(mem.dm[7'h22], d6);
		chk(mem.dm[7'h14], {pre[7'h14][6:0], a1[8]});
		chk(flag_c, pre[7'h14][7]);
		chk(mem.dm[7'h15], put_bit(pre[7'h15], b, 1'b1));
		chk(mem.dm[7'h16], put_bit(pre[7'h16], b2, 1'b0));
		chk(mem.dm[7'h23], d6);
		chk(flag_z, 1'b1);
		chk(flag_ac, 16'(r0[3:0] != 4'h0));
		chk(flag_ov, 16'(r0[7] & ~a1[7]));
		chk(mem.dm[7'h24], w[7:0]);
		chk(tbl_high, w[13:8]);
		chk(mem.dm[7'h25], pre[7'h25]);
		chk(acc, 8'h1e);
		chk(int_enable, 1'b1);
		wake_pin = 1'b1;
		wait_pd(1'b0);
		wake_pin = 1'b0;
		wait_pd(1'b1);
		chk(mem.dm[7'h26], 8'h1e);
		int_taken = 1'b1;
		@(posedge clk);
		#1;
		int_taken = 1'b0;
		chk(int_enable, 1'b0);
		summarize();
	end
endmodule
